// File: bench/accumulator_load_from_ctrl_regs_tb.sv
// self-checking bench of the accumulator load decoder
`timescale 1ns/100ps
`default_nettype none
module accumulator_load_from_ctrl_regs_tb;
    logic clock_i, rst_n_i, instr_valid_i, acc_we_o, carry_we_o, skip_o;
    logic [9:0] instr_i, tc_op;
    logic [3:0] acc_data_o, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wstrb_i, hold, st_src;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
    logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o, s_axi_bvalid_o, s_axi_bready_i;
    logic s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i, en;
    alfcr_pkg::alfcr_src_t src_i;
    int err_total, comparisons, cnt;
    logic [4:0] q[$];
    logic [9:0] ops[8] = '{alfcr_pkg::OP_ADC_CTRL_B, alfcr_pkg::OP_ADC_CTRL_C, alfcr_pkg::OP_STACK_PTR,
        alfcr_pkg::OP_IRQ_CTRL_A, alfcr_pkg::OP_IRQ_CTRL_B, alfcr_pkg::OP_TIMER_CTRL_A,
        alfcr_pkg::OP_TIMER_CTRL_B, alfcr_pkg::OP_TIMER_CTRL_C};
    alfcr_decoder i_dut (.clock_i, .rst_n_i, .instr_i, .instr_valid_i, .src_i, .acc_we_o, .acc_data_o,
        .carry_we_o, .skip_o, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
        .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
        .s_axi_rvalid_o, .s_axi_rready_i);
    // ==========================================================
    // helpers
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        if (err_total == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // reference: {we, data, source code}
    function automatic logic [8:0] model(logic [9:0] op, logic v, alfcr_pkg::alfcr_src_t s);
        if (!(v && en)) return 9'h000;
        if (op == tc_op) return {1'b1, s.timer_ctrl_c, 4'h8};
        case (op)
            alfcr_pkg::OP_ADC_CTRL_B:   return {1'b1, s.adc_ctrl_b, 4'h1};
            alfcr_pkg::OP_ADC_CTRL_C:   return {1'b1, s.adc_ctrl_c, 4'h2};
            alfcr_pkg::OP_STACK_PTR:    return {2'b10, s.stack_pointer, 4'h3};
            alfcr_pkg::OP_IRQ_CTRL_A:   return {1'b1, s.irq_ctrl_a, 4'h4};
            alfcr_pkg::OP_IRQ_CTRL_B:   return {1'b1, s.irq_ctrl_b, 4'h5};
            alfcr_pkg::OP_TIMER_CTRL_A: return {1'b1, s.timer_ctrl_a, 4'h6};
            alfcr_pkg::OP_TIMER_CTRL_B: return {1'b1, s.timer_ctrl_b, 4'h7};
            default:                    return 9'h000;
        endcase
    endfunction
    task automatic run(int n);
        logic [9:0] op;
        logic v;
        alfcr_pkg::alfcr_src_t s;
        logic [8:0] r;
        logic [4:0] e;
        int k;
        for (int i = 0; i <= n; i++) begin
            k = $urandom_range(9);
            op = (k == 9) ? 10'($urandom) : ((k == 8) ? tc_op : ops[k]);
            v = (i < n) && ($urandom_range(3) != 0);
            s = 31'($urandom);
            @(posedge clock_i);
            instr_i <= op;
            instr_valid_i <= v;
            src_i <= s;
            r = model(op, v, s);
            if (r[8]) begin
                hold = r[7:4];
                st_src = r[3:0];
                cnt++;
            end
            q.push_back({r[8], hold});
            @(negedge clock_i);
            if (q.size() > 1) begin
                e = q.pop_front();
                chk("acc_we", 32'(e[4]), 32'(acc_we_o));
                chk("acc_data", 32'(e[3:0]), 32'(acc_data_o));
                chk("carry_skip", 32'h0, 32'({carry_we_o, skip_o}));
            end
        end
    endtask
    task automatic wr(logic [3:0] a, logic [31:0] d, logic [1:0] er);
        bit aw, w, b;
        @(posedge clock_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge clock_i);
            if (i == 0) chk("aw_w_ready", 32'h3, 32'({s_axi_awready_o, s_axi_wready_o}));
            aw = s_axi_awvalid_i && s_axi_awready_o;
            w = s_axi_wvalid_i && s_axi_wready_o;
            b = s_axi_bvalid_o;
            if (b) chk("bresp", 32'(er), 32'(s_axi_bresp_o));
            @(posedge clock_i);
            if (aw) s_axi_awvalid_i <= 1'b0;
            if (w) s_axi_wvalid_i <= 1'b0;
            if (b) begin
                s_axi_bready_i <= 1'b0;
                return;
            end
        end
        err_total++;
        conclude();
    endtask
    task automatic rd(logic [3:0] a, logic [31:0] ed, logic [1:0] er);
        bit ar, rv;
        @(posedge clock_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        for (int i = 0; i < 50; i++) begin
            @(negedge clock_i);
            if (i == 0) chk("arready", 32'h1, 32'(s_axi_arready_o));
            ar = s_axi_arvalid_i && s_axi_arready_o;
            rv = s_axi_rvalid_o;
            if (rv) begin
                chk("rresp", 32'(er), 32'(s_axi_rresp_o));
                chk("rdata", ed, s_axi_rdata_o);
            end
            @(posedge clock_i);
            if (ar) s_axi_arvalid_i <= 1'b0;
            if (rv) begin
                s_axi_rready_i <= 1'b0;
                return;
            end
        end
        err_total++;
        conclude();
    endtask
    // ==========================================================
    // stimulus
    initial begin
        clock_i = 0;
        forever #50 clock_i = ~clock_i;
    end
    initial begin
        {rst_n_i, instr_i, instr_valid_i, src_i, s_axi_awaddr_i, s_axi_awvalid_i, s_axi_wdata_i} = '0;
        {s_axi_wvalid_i, s_axi_bready_i, s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
        s_axi_wstrb_i = 4'hF;
        {tc_op, en, hold, st_src, cnt, err_total, comparisons} = {10'h24D, 1'b1, 8'h00, 96'h0};
        void'($urandom(32'hB674));
        repeat (4) @(posedge clock_i);
        rst_n_i <= 1'b1;
        rd(alfcr_pkg::ADDR_TIMER_OP, 32'h24D, alfcr_pkg::RESP_OKAY);
        run(300);
        rd(alfcr_pkg::ADDR_STATUS, {cnt[15:0], 8'h00, st_src, hold}, alfcr_pkg::RESP_OKAY);
        wr(alfcr_pkg::ADDR_CTRL, 32'h0, alfcr_pkg::RESP_OKAY);
        en = 1'b0;
        run(40);
        wr(alfcr_pkg::ADDR_CTRL, 32'h1, alfcr_pkg::RESP_OKAY);
        wr(alfcr_pkg::ADDR_TIMER_OP, 32'h1A3, alfcr_pkg::RESP_OKAY);
        {en, tc_op} = {1'b1, 10'h1A3};
        run(150);
        s_axi_wstrb_i <= 4'h1;
        wr(alfcr_pkg::ADDR_TIMER_OP, 32'h2C7, alfcr_pkg::RESP_OKAY);
        s_axi_wstrb_i <= 4'hF;
        rd(alfcr_pkg::ADDR_TIMER_OP, 32'h1C7, alfcr_pkg::RESP_OKAY);
        wr(4'hC, 32'h5, alfcr_pkg::RESP_SLVERR);
        rd(4'hC, 32'h0, alfcr_pkg::RESP_SLVERR);
        wr(alfcr_pkg::ADDR_STATUS, 32'hFFFF, alfcr_pkg::RESP_OKAY);
        rd(alfcr_pkg::ADDR_STATUS, {cnt[15:0], 8'h00, st_src, hold}, alfcr_pkg::RESP_OKAY);
        conclude();
    end
endmodule
bind alfcr_decoder alfcr_asserts i_chk (.clock_i, .rst_n_i, .instr_i, .instr_valid_i, .src_i, .acc_we_o,
    .acc_data_o, .carry_we_o, .skip_o);
`default_nettype wire

// File: bench/alfcr_asserts.sv
// checker of the accumulator load decoder outputs
`timescale 1ns/100ps
`default_nettype none
module alfcr_asserts (
    input wire logic                  clock_i,
    input wire logic                  rst_n_i,
    input wire logic [9:0]            instr_i,
    input wire logic                  instr_valid_i,
    input wire alfcr_pkg::alfcr_src_t src_i,
    input wire logic                  acc_we_o,
    input wire logic [3:0]            acc_data_o,
    input wire logic                  carry_we_o,
    input wire logic                  skip_o
);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // loads
    property p_adc_b; acc_we_o && $past(instr_i) == alfcr_pkg::OP_ADC_CTRL_B |->
        acc_data_o == $past(src_i.adc_ctrl_b); endproperty
    a_adc_b: assert property (p_adc_b) else $error("adc b load wrong");
    property p_adc_c; acc_we_o && $past(instr_i) == alfcr_pkg::OP_ADC_CTRL_C |->
        acc_data_o == $past(src_i.adc_ctrl_c); endproperty
    a_adc_c: assert property (p_adc_c) else $error("adc c load wrong");
    property p_sp; acc_we_o && $past(instr_i) == alfcr_pkg::OP_STACK_PTR |->
        acc_data_o == {1'b0, $past(src_i.stack_pointer)}; endproperty
    a_sp: assert property (p_sp) else $error("stack load wrong");
    property p_irq_a; acc_we_o && $past(instr_i) == alfcr_pkg::OP_IRQ_CTRL_A |->
        acc_data_o == $past(src_i.irq_ctrl_a); endproperty
    a_irq_a: assert property (p_irq_a) else $error("irq a load wrong");
    property p_irq_b; acc_we_o && $past(instr_i) == alfcr_pkg::OP_IRQ_CTRL_B |->
        acc_data_o == $past(src_i.irq_ctrl_b); endproperty
    a_irq_b: assert property (p_irq_b) else $error("irq b load wrong");
    property p_tmr_a; acc_we_o && $past(instr_i) == alfcr_pkg::OP_TIMER_CTRL_A |->
        acc_data_o == $past(src_i.timer_ctrl_a); endproperty
    a_tmr_a: assert property (p_tmr_a) else $error("timer a load wrong");
    property p_tmr_b; acc_we_o && $past(instr_i) == alfcr_pkg::OP_TIMER_CTRL_B |->
        acc_data_o == $past(src_i.timer_ctrl_b); endproperty
    a_tmr_b: assert property (p_tmr_b) else $error("timer b load wrong");
    property p_quiet; !carry_we_o && !skip_o; endproperty
    a_quiet: assert property (p_quiet) else $error("carry or skip raised");
    property p_hold; !acc_we_o |-> $stable(acc_data_o); endproperty
    a_hold: assert property (p_hold) else $error("data moved without load");
    property p_cause; acc_we_o |-> $past(instr_valid_i); endproperty
    a_cause: assert property (p_cause) else $error("load without instruction");
    c_sp: cover property (acc_we_o && $past(instr_i) == alfcr_pkg::OP_STACK_PTR);
    c_b2b: cover property (acc_we_o ##1 acc_we_o);
    c_gap: cover property (acc_we_o ##1 !acc_we_o);
endmodule
`default_nettype wire

// File: src/alfcr_decoder.sv
// decoder and executor of the accumulator load from control register instructions
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - opcode 245h loads adc_ctrl_b into accumulator, one cycle, no carry, no skip
// - opcode 246h loads adc_ctrl_c into accumulator, one cycle, no carry, no skip
// - opcode 050h loads stack_pointer into accumulator bits 2..0, one cycle
// - stack pointer load writes zero into accumulator bit 3
// - opcode 054h loads irq_ctrl_a into accumulator, one cycle, no carry, no skip
// - opcode 055h loads irq_ctrl_b into accumulator, one cycle, no carry, no skip
// - opcode 24Bh loads timer_ctrl_a into accumulator, one cycle, no carry, no skip
// - opcode 24Ch loads timer_ctrl_b into accumulator, one cycle, no carry, no skip
// - a programmable opcode loads timer_ctrl_c into accumulator, one cycle
module alfcr_decoder (
    input  wire logic                 clock_i,
    input  wire logic                 rst_n_i,
    input  wire logic [9:0]           instr_i,
    input  wire logic                 instr_valid_i,
    input  wire alfcr_pkg::alfcr_src_t src_i,
    output logic                      acc_we_o,
    output logic [3:0]                acc_data_o,
    output logic                      carry_we_o,
    output logic                      skip_o,
    input  wire logic [3:0]           s_axi_awaddr_i,
    input  wire logic                 s_axi_awvalid_i,
    output logic                      s_axi_awready_o,
    input  wire logic [31:0]          s_axi_wdata_i,
    input  wire logic [3:0]           s_axi_wstrb_i,
    input  wire logic                 s_axi_wvalid_i,
    output logic                      s_axi_wready_o,
    output logic [1:0]                s_axi_bresp_o,
    output logic                      s_axi_bvalid_o,
    input  wire logic                 s_axi_bready_i,
    input  wire logic [3:0]           s_axi_araddr_i,
    input  wire logic                 s_axi_arvalid_i,
    output logic                      s_axi_arready_o,
    output logic [31:0]               s_axi_rdata_o,
    output logic [1:0]                s_axi_rresp_o,
    output logic                      s_axi_rvalid_o,
    input  wire logic                 s_axi_rready_i
);
    // ==========================================================
    // decode
    function automatic alfcr_pkg::alfcr_sel_t decode(input logic [9:0] op, input logic [9:0] tc_op);
        alfcr_pkg::alfcr_sel_t s;
        s = alfcr_pkg::SRC_NONE;
        if (op == tc_op) begin
            s = alfcr_pkg::SRC_TIMER_CTRL_C;
        end else begin
            unique case (op)
                alfcr_pkg::OP_ADC_CTRL_B:   s = alfcr_pkg::SRC_ADC_CTRL_B;
                alfcr_pkg::OP_ADC_CTRL_C:   s = alfcr_pkg::SRC_ADC_CTRL_C;
                alfcr_pkg::OP_STACK_PTR:    s = alfcr_pkg::SRC_STACK_PTR;
                alfcr_pkg::OP_IRQ_CTRL_A:   s = alfcr_pkg::SRC_IRQ_CTRL_A;
                alfcr_pkg::OP_IRQ_CTRL_B:   s = alfcr_pkg::SRC_IRQ_CTRL_B;
                alfcr_pkg::OP_TIMER_CTRL_A: s = alfcr_pkg::SRC_TIMER_CTRL_A;
                alfcr_pkg::OP_TIMER_CTRL_B: s = alfcr_pkg::SRC_TIMER_CTRL_B;
                default:                    s = alfcr_pkg::SRC_NONE;
            endcase
        end
        return s;
    endfunction

    // ==========================================================
    // state
    logic                  en_reg, en_next;
    logic [9:0]            tc_op_reg, tc_op_next;
    logic                  acc_we_reg, acc_we_next;
    logic [3:0]            acc_data_reg, acc_data_next;
    alfcr_pkg::alfcr_sel_t last_src_reg, last_src_next;
    logic [15:0]           cnt_reg, cnt_next;
    logic                  aw_full_reg, aw_full_next;
    logic [3:0]            aw_addr_reg, aw_addr_next;
    logic                  w_full_reg, w_full_next;
    logic [31:0]           w_data_reg, w_data_next;
    logic [3:0]            w_strb_reg, w_strb_next;
    logic                  bvalid_reg, bvalid_next;
    logic [1:0]            bresp_reg, bresp_next;
    logic                  rvalid_reg, rvalid_next;
    logic [1:0]            rresp_reg, rresp_next;
    logic [31:0]           rdata_reg, rdata_next;
    alfcr_pkg::alfcr_sel_t sel;
    logic                  do_wr;

    // ==========================================================
    // execute
    always_comb begin
        sel           = decode(instr_i, tc_op_reg);
        acc_we_next   = 1'b0;
        acc_data_next = acc_data_reg;
        last_src_next = last_src_reg;
        cnt_next      = cnt_reg;
        if (instr_valid_i && en_reg && sel != alfcr_pkg::SRC_NONE) begin
            acc_we_next   = 1'b1;
            last_src_next = sel;
            cnt_next      = cnt_reg + 16'h0001;
            unique case (sel)
                alfcr_pkg::SRC_ADC_CTRL_B:   acc_data_next = src_i.adc_ctrl_b;
                alfcr_pkg::SRC_ADC_CTRL_C:   acc_data_next = src_i.adc_ctrl_c;
                alfcr_pkg::SRC_STACK_PTR:    acc_data_next = {1'b0, src_i.stack_pointer};
                alfcr_pkg::SRC_IRQ_CTRL_A:   acc_data_next = src_i.irq_ctrl_a;
                alfcr_pkg::SRC_IRQ_CTRL_B:   acc_data_next = src_i.irq_ctrl_b;
                alfcr_pkg::SRC_TIMER_CTRL_A: acc_data_next = src_i.timer_ctrl_a;
                alfcr_pkg::SRC_TIMER_CTRL_B: acc_data_next = src_i.timer_ctrl_b;
                alfcr_pkg::SRC_TIMER_CTRL_C: acc_data_next = src_i.timer_ctrl_c;
                default:                     acc_data_next = acc_data_reg;
            endcase
        end
    end

    // ==========================================================
    // register bus
    always_comb begin
        en_next      = en_reg;
        tc_op_next   = tc_op_reg;
        aw_full_next = aw_full_reg;
        aw_addr_next = aw_addr_reg;
        w_full_next  = w_full_reg;
        w_data_next  = w_data_reg;
        w_strb_next  = w_strb_reg;
        bvalid_next  = bvalid_reg;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        do_wr        = aw_full_reg && w_full_reg && !bvalid_reg;
        if (s_axi_awvalid_i && !aw_full_reg) begin
            aw_full_next = 1'b1;
            aw_addr_next = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !w_full_reg) begin
            w_full_next = 1'b1;
            w_data_next = s_axi_wdata_i;
            w_strb_next = s_axi_wstrb_i;
        end
        if (do_wr) begin
            aw_full_next = 1'b0;
            w_full_next  = 1'b0;
            bvalid_next  = 1'b1;
            bresp_next   = alfcr_pkg::RESP_OKAY;
            unique case (aw_addr_reg)
                alfcr_pkg::ADDR_CTRL: begin
                    if (w_strb_reg[0]) begin
                        en_next = w_data_reg[alfcr_pkg::CTRL_EN_BIT];
                    end
                end
                alfcr_pkg::ADDR_TIMER_OP: begin
                    if (w_strb_reg[0]) begin
                        tc_op_next[7:0] = w_data_reg[7:0];
                    end
                    if (w_strb_reg[1]) begin
                        tc_op_next[9:8] = w_data_reg[9:8];
                    end
                end
                alfcr_pkg::ADDR_STATUS: bresp_next = alfcr_pkg::RESP_OKAY;
                default:                bresp_next = alfcr_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid_reg && s_axi_bready_i) begin
            bvalid_next = 1'b0;
        end
        if (rvalid_reg) begin
            if (s_axi_rready_i) begin
                rvalid_next = 1'b0;
            end
        end else if (s_axi_arvalid_i) begin
            rvalid_next = 1'b1;
            rresp_next  = alfcr_pkg::RESP_OKAY;
            rdata_next  = 32'h00000000;
            unique case (s_axi_araddr_i)
                alfcr_pkg::ADDR_CTRL:     rdata_next[alfcr_pkg::CTRL_EN_BIT] = en_reg;
                alfcr_pkg::ADDR_TIMER_OP: rdata_next[9:0] = tc_op_reg;
                alfcr_pkg::ADDR_STATUS: begin
                    rdata_next[alfcr_pkg::ST_VAL_LSB +: 4]  = acc_data_reg;
                    rdata_next[alfcr_pkg::ST_SRC_LSB +: 4]  = last_src_reg;
                    rdata_next[alfcr_pkg::ST_CNT_LSB +: 16] = cnt_reg;
                end
                default:                  rresp_next = alfcr_pkg::RESP_SLVERR;
            endcase
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_reg       <= alfcr_pkg::CTRL_EN_RST;
            tc_op_reg    <= alfcr_pkg::OP_TIMER_CTRL_C;
            acc_we_reg   <= 1'b0;
            acc_data_reg <= 4'h0;
            last_src_reg <= alfcr_pkg::SRC_NONE;
            cnt_reg      <= 16'h0000;
            aw_full_reg  <= 1'b0;
            aw_addr_reg  <= 4'h0;
            w_full_reg   <= 1'b0;
            w_data_reg   <= 32'h00000000;
            w_strb_reg   <= 4'h0;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= 2'h0;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= 2'h0;
            rdata_reg    <= 32'h00000000;
        end else begin
            en_reg       <= en_next;
            tc_op_reg    <= tc_op_next;
            acc_we_reg   <= acc_we_next;
            acc_data_reg <= acc_data_next;
            last_src_reg <= last_src_next;
            cnt_reg      <= cnt_next;
            aw_full_reg  <= aw_full_next;
            aw_addr_reg  <= aw_addr_next;
            w_full_reg   <= w_full_next;
            w_data_reg   <= w_data_next;
            w_strb_reg   <= w_strb_next;
            bvalid_reg   <= bvalid_next;
            bresp_reg    <= bresp_next;
            rvalid_reg   <= rvalid_next;
            rresp_reg    <= rresp_next;
            rdata_reg    <= rdata_next;
        end
    end

    // ==========================================================
    // outputs
    assign acc_we_o        = acc_we_reg;
    assign acc_data_o      = acc_data_reg;
    assign carry_we_o      = 1'b0;
    assign skip_o          = 1'b0;
    assign s_axi_awready_o = !aw_full_reg;
    assign s_axi_wready_o  = !w_full_reg;
    assign s_axi_bvalid_o  = bvalid_reg;
    assign s_axi_bresp_o   = bresp_reg;
    assign s_axi_arready_o = !rvalid_reg;
    assign s_axi_rvalid_o  = rvalid_reg;
    assign s_axi_rresp_o   = rresp_reg;
    assign s_axi_rdata_o   = rdata_reg;
endmodule
`default_nettype wire

// File: src/alfcr_pkg.sv
// package for the accumulator load from control register decoder
package alfcr_pkg;
    // ==========================================================
    // opcodes
    localparam logic [9:0] OP_ADC_CTRL_B   = 10'h245;
    localparam logic [9:0] OP_ADC_CTRL_C   = 10'h246;
    localparam logic [9:0] OP_STACK_PTR    = 10'h050;
    localparam logic [9:0] OP_IRQ_CTRL_A   = 10'h054;
    localparam logic [9:0] OP_IRQ_CTRL_B   = 10'h055;
    localparam logic [9:0] OP_TIMER_CTRL_A = 10'h24B;
    localparam logic [9:0] OP_TIMER_CTRL_B = 10'h24C;
    localparam logic [9:0] OP_TIMER_CTRL_C = 10'h24D;
    // ==========================================================
    // register map
    localparam logic [3:0] ADDR_CTRL      = 4'h0;
    localparam logic [3:0] ADDR_TIMER_OP  = 4'h4;
    localparam logic [3:0] ADDR_STATUS    = 4'h8;
    localparam int         CTRL_EN_BIT    = 0;
    localparam logic       CTRL_EN_RST    = 1'b1;
    localparam int         ST_VAL_LSB     = 0;
    localparam int         ST_SRC_LSB     = 4;
    localparam int         ST_CNT_LSB     = 16;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;
    // ==========================================================
    // types
    typedef struct packed {
        logic [3:0] adc_ctrl_b;
        logic [3:0] adc_ctrl_c;
        logic [3:0] irq_ctrl_a;
        logic [3:0] irq_ctrl_b;
        logic [3:0] timer_ctrl_a;
        logic [3:0] timer_ctrl_b;
        logic [3:0] timer_ctrl_c;
        logic [2:0] stack_pointer;
    } alfcr_src_t;

    typedef enum logic [3:0] {
        SRC_NONE         = 4'b0000,
        SRC_ADC_CTRL_B   = 4'b0001,
        SRC_ADC_CTRL_C   = 4'b0010,
        SRC_STACK_PTR    = 4'b0011,
        SRC_IRQ_CTRL_A   = 4'b0100,
        SRC_IRQ_CTRL_B   = 4'b0101,
        SRC_TIMER_CTRL_A = 4'b0110,
        SRC_TIMER_CTRL_B = 4'b0111,
        SRC_TIMER_CTRL_C = 4'b1000
    } alfcr_sel_t;
endpackage
